/* design/ach_defines.vh */
/*
  Constants of the serial API frame handler: frame bytes, field indexes,
  status codes and timing. Assumes inclusion by ach_frame_handler.v only.
*/
`ifndef ACH_DEFINES_VH
`define ACH_DEFINES_VH

// ==========================================================================
// Frame framing
`define ACH_DELIM      8'h7e
`define ACH_SUM_GOOD   8'hff
`define ACH_T_AT       8'h08
`define ACH_T_ATQ      8'h09
`define ACH_T_TX       8'h20
`define ACH_T_ATR      8'h88
`define ACH_T_ST       8'h89
`define ACH_T_RX       8'hb0

// ==========================================================================
// Field indexes inside frame data
`define ACH_I_ID       16'h0001
`define ACH_I_C1       16'h0002
`define ACH_I_C2       16'h0003
`define ACH_I_PV       16'h0004
`define ACH_I_OPT      16'h000b
`define ACH_I_PAY      16'h000c
`define ACH_MAX_PAY    16'd1500
`define ACH_OPT_CLOSE  1
`define ACH_PROTO_TCP  8'h01

// ==========================================================================
// Status codes and command names
`define ACH_ST_OK      8'h00
`define ACH_ST_RES     8'h32
`define ACH_ST_LONG    8'h74
`define ACH_ST_CLOSED  8'h83
`define ACH_AC1        8'h41
`define ACH_AC2        8'h43
`define ACH_TM1        8'h54
`define ACH_TM2        8'h4d
`define ACH_PAR_RST    8'h00

// ==========================================================================
// Timing
`define ACH_CLK_NS     20
`define ACH_TICK_NS    100000000
`define ACH_TICK_CYC   ((`ACH_TICK_NS + `ACH_CLK_NS - 1) / `ACH_CLK_NS)

`endif

/* design/ach_frame_handler.v */
/*
  Serial API frame handler: parses host frames, keeps the parameter store,
  the socket table and idle timeouts, and builds response frames.
  Assumes byte streams with valid/ready on both serial directions and a
  network stack that takes payload bytes per socket and offers received data.
*/
`timescale 1ns/100ps
`default_nettype none
`include "ach_defines.vh"

module ach_frame_handler #(
  parameter NSOCK    = 7,
  parameter SW       = 3,
  parameter TICK_CYC = `ACH_TICK_CYC
) (
  // Clock and reset
  input  wire              CLK_SYS,
  input  wire              RST,
  // Serial bytes from the host
  input  wire              SER_RX_VALID,
  input  wire [7:0]        SER_RX_DATA,
  output wire              SER_RX_READY,
  // Serial bytes to the host
  output wire              SER_TX_VALID,
  output wire [7:0]        SER_TX_DATA,
  input  wire              SER_TX_READY,
  // Payload to the network
  output wire              NET_TX_VALID,
  output wire [7:0]        NET_TX_DATA,
  output wire              NET_TX_LAST,
  output wire [SW-1:0]     NET_TX_SOCK,
  input  wire              NET_TX_READY,
  output wire              NET_TX_DONE,
  output wire              NET_TX_OK,
  // Socket control
  output wire [NSOCK-1:0]  NET_OPEN,
  output wire [NSOCK-1:0]  NET_CLOSE,
  output wire [31:0]       NET_ADDR,
  output wire [15:0]       NET_DPORT,
  output wire [15:0]       NET_SPORT,
  output wire [7:0]        NET_PROTO,
  // Data from the network
  input  wire              NET_RX_VALID,
  input  wire [7:0]        NET_RX_DATA,
  input  wire              NET_RX_LAST,
  input  wire [SW-1:0]     NET_RX_SOCK,
  input  wire [15:0]       NET_RX_LEN,
  output wire              NET_RX_READY,
  // Status
  output wire [7:0]        CONN_TIMEOUT,
  output wire              SUM_ERR
);

  localparam P_SYNC = 3'h0, P_L1 = 3'h1, P_L2 = 3'h2, P_DAT = 3'h3, P_RES = 3'h4, P_SUM = 3'h5;
  localparam O_IDLE = 2'h0, O_HDR = 2'h1, O_PAY = 2'h2, O_SUM = 2'h3;
  localparam K_AT = 2'h0, K_ST = 2'h1, K_RX = 2'h2;

  function [3:0] pidx;
    input [7:0] a;
    input [7:0] b;
    pidx = {a[1:0], b[1:0]};
  endfunction

  // ========================================================================
  // Parser state
  reg  [2:0]   ps_r;
  reg  [15:0]  len_r, idx_r, dport_r, sport_r;
  reg  [7:0]   sum_r, typ_r, fid_r, c1_r, c2_r, pv_r, proto_r, opt_r, err_r;
  reg  [31:0]  addr_r;
  reg  [SW-1:0] sock_r;
  reg          rdone_r, serr_r;
  reg          at_pend_r, at_hv_r, st_pend_r;
  reg  [7:0]   at_id_r, at_c1_r, at_c2_r, at_val_r, st_id_r, st_code_r;
  reg  [7:0]   act_r [0:15];
  reg  [7:0]   pend_r [0:15];
  reg  [15:0]  pvb_r;
  reg          nv_r, nl_r, done_r, dok_r;
  reg  [7:0]   nd_r;
  // Socket table
  reg  [NSOCK-1:0] sk_v_r, open_r, close_r;
  reg  [31:0]  sk_a_r [0:NSOCK-1];
  reg  [15:0]  sk_dp_r [0:NSOCK-1];
  reg  [15:0]  sk_sp_r [0:NSOCK-1];
  reg  [7:0]   sk_pr_r [0:NSOCK-1];
  reg  [7:0]   idle_r [0:NSOCK-1];
  reg  [31:0]  tk_r;
  // Emitter and output buffer
  reg  [1:0]   os_r, kind_r, fc_r;
  reg  [3:0]   oi_r;
  reg  [7:0]   osum_r;
  reg  [SW-1:0] rxs_r;
  reg  [15:0]  rxl_r;
  reg  [7:0]   fm_r [0:1];
  reg          fw_r, fr_r;

  wire [15:0] pay_n   = idx_r - `ACH_I_PAY;
  wire        is_tx   = typ_r == `ACH_T_TX;
  wire        pay_sel = ps_r == P_DAT && is_tx && rdone_r && idx_r >= `ACH_I_PAY;
  wire        fwd_sel = pay_sel && err_r == `ACH_ST_OK && pay_n < `ACH_MAX_PAY;
  wire        resp_busy = at_pend_r | st_pend_r | nv_r;
  reg         rx_rdy;
  always @* begin
    case (ps_r)
      P_RES:   rx_rdy = 1'b0;
      P_SUM:   rx_rdy = !resp_busy;
      default: rx_rdy = fwd_sel ? (!nv_r || NET_TX_READY) : 1'b1;
    endcase
  end
  wire take     = SER_RX_VALID & rx_rdy;
  wire sum_ok   = (sum_r + SER_RX_DATA) == `ACH_SUM_GOOD;
  wire sum_take = take && ps_r == P_SUM;
  wire is_at    = typ_r == `ACH_T_AT || typ_r == `ACH_T_ATQ;
  wire [3:0] pi = pidx(c1_r, c2_r);
  wire has_p    = len_r > `ACH_I_PV;
  wire is_ac    = c1_r == `ACH_AC1 && c2_r == `ACH_AC2;
  wire at_do    = sum_take && sum_ok && is_at && len_r >= `ACH_I_PV;
  wire apply    = at_do && (typ_r == `ACH_T_AT || is_ac);
  // Protocol must be TCP; for UDP the close bit is never looked at.
  wire tcp_close = sum_take && sum_ok && is_tx && rdone_r && err_r == `ACH_ST_OK &&
                   proto_r == `ACH_PROTO_TCP && opt_r[`ACH_OPT_CLOSE];

  // ========================================================================
  // Socket lookup
  reg [SW-1:0] m_i, f_i;
  reg          m_hit, f_hit;
  integer s;
  integer c;
  always @* begin
    m_hit = 1'b0;
    f_hit = 1'b0;
    m_i = {SW{1'b0}};
    f_i = {SW{1'b0}};
    for (c = NSOCK - 1; c >= 0; c = c - 1) begin
      if (sk_v_r[c] && sk_a_r[c] == addr_r && sk_dp_r[c] == dport_r &&
          (sport_r == 16'h0000 || sk_sp_r[c] == sport_r)) begin
        m_hit = 1'b1;
        m_i = c[SW-1:0];
      end
      if (!sk_v_r[c]) begin
        f_hit = 1'b1;
        f_i = c[SW-1:0];
      end
    end
  end
  wire alloc = ps_r == P_RES && !m_hit && sport_r == 16'h0000 && f_hit;

  // ========================================================================
  // Emitter handshake
  wire [1:0] fc_lim = 2'h2;
  wire f_rdy = fc_r != fc_lim;
  wire f_v   = os_r == O_HDR || os_r == O_SUM || (os_r == O_PAY && NET_RX_VALID);
  reg  [7:0] hb;
  wire [7:0] f_d = os_r == O_PAY ? NET_RX_DATA : os_r == O_SUM ? (`ACH_SUM_GOOD - osum_r) : hb;
  wire f_in  = f_v & f_rdy;
  wire f_out = fc_r != 2'h0 && SER_TX_READY;
  wire fin   = os_r == O_SUM && f_in;
  wire rx_mv = os_r == O_PAY && f_in;

  // ========================================================================
  // Parser, parameter store and response latches
  integer j;
  always @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      ps_r <= P_SYNC; len_r <= 16'h0; idx_r <= 16'h0; sum_r <= 8'h0;
      typ_r <= 8'h0; fid_r <= 8'h0; c1_r <= 8'h0; c2_r <= 8'h0; pv_r <= 8'h0;
      addr_r <= 32'h0; dport_r <= 16'h0; sport_r <= 16'h0; proto_r <= 8'h0;
      opt_r <= 8'h0; err_r <= `ACH_ST_OK; sock_r <= {SW{1'b0}}; rdone_r <= 1'b0;
      serr_r <= 1'b0; at_pend_r <= 1'b0; at_hv_r <= 1'b0; at_id_r <= 8'h0;
      at_c1_r <= 8'h0; at_c2_r <= 8'h0; at_val_r <= 8'h0; st_pend_r <= 1'b0;
      st_id_r <= 8'h0; st_code_r <= 8'h0; pvb_r <= 16'h0;
      for (j = 0; j < 16; j = j + 1) begin
        act_r[j] <= `ACH_PAR_RST;
        pend_r[j] <= `ACH_PAR_RST;
      end
    end else begin
      serr_r <= 1'b0;
      if (fin && kind_r == K_AT) at_pend_r <= 1'b0;
      if (fin && kind_r == K_ST) st_pend_r <= 1'b0;
      case (ps_r)
        P_SYNC: if (take && SER_RX_DATA == `ACH_DELIM) ps_r <= P_L1;
        P_L1: if (take) begin
          len_r[15:8] <= SER_RX_DATA;
          ps_r <= P_L2;
        end
        P_L2: if (take) begin
          len_r[7:0] <= SER_RX_DATA;
          idx_r <= 16'h0;
          sum_r <= 8'h0;
          rdone_r <= 1'b0;
          err_r <= `ACH_ST_OK;
          ps_r <= {len_r[15:8], SER_RX_DATA} == 16'h0 ? P_SUM : P_DAT;
        end
        P_DAT: if (take) begin
          sum_r <= sum_r + SER_RX_DATA;
          idx_r <= idx_r + 16'h1;
          // Field capture by position; name bytes ride in c1/c2.
          case (idx_r)
            16'h0: typ_r <= SER_RX_DATA;
            `ACH_I_ID: fid_r <= SER_RX_DATA;
            `ACH_I_C1: begin c1_r <= SER_RX_DATA; addr_r[31:24] <= SER_RX_DATA; end
            `ACH_I_C2: begin c2_r <= SER_RX_DATA; addr_r[23:16] <= SER_RX_DATA; end
            `ACH_I_PV: begin pv_r <= SER_RX_DATA; addr_r[15:8] <= SER_RX_DATA; end
            16'h5: addr_r[7:0] <= SER_RX_DATA;
            16'h6: dport_r[15:8] <= SER_RX_DATA;
            16'h7: dport_r[7:0] <= SER_RX_DATA;
            16'h8: sport_r[15:8] <= SER_RX_DATA;
            16'h9: sport_r[7:0] <= SER_RX_DATA;
            16'ha: proto_r <= SER_RX_DATA;
            `ACH_I_OPT: opt_r <= SER_RX_DATA;
            default: ;
          endcase
          // Bytes past the limit are dropped and the status reports it.
          if (pay_sel && err_r == `ACH_ST_OK && pay_n >= `ACH_MAX_PAY)
            err_r <= `ACH_ST_LONG;
          if (is_tx && idx_r == `ACH_I_OPT) ps_r <= P_RES;
          else if (idx_r + 16'h1 == len_r) ps_r <= P_SUM;
        end
        P_RES: begin
          rdone_r <= 1'b1;
          sock_r <= m_hit ? m_i : f_i;
          if (!m_hit && !alloc)
            err_r <= sport_r == 16'h0000 ? `ACH_ST_RES : `ACH_ST_CLOSED;
          ps_r <= idx_r == len_r ? P_SUM : P_DAT;
        end
        P_SUM: if (take) begin
          ps_r <= P_SYNC;
          serr_r <= !sum_ok;
          if (sum_ok && is_tx && rdone_r && fid_r != 8'h00) begin
            st_pend_r <= 1'b1;
            st_id_r <= fid_r;
            st_code_r <= err_r;
          end
          if (at_do) begin
            // One response frame per command with a nonzero frame ID; P_SUM holds the next checksum byte until it is sent.
            at_pend_r <= fid_r != 8'h00;
            at_id_r <= fid_r;
            at_c1_r <= c1_r;
            at_c2_r <= c2_r;
            at_hv_r <= !has_p && !is_ac;
            at_val_r <= (typ_r == `ACH_T_AT && pvb_r[pi]) ? pend_r[pi] : act_r[pi];
            if (typ_r == `ACH_T_ATQ && has_p && !is_ac) begin
              pend_r[pi] <= pv_r;
            end
          end
          if (apply) begin
            for (j = 0; j < 16; j = j + 1)
              if (pvb_r[j]) act_r[j] <= pend_r[j];
            if (typ_r == `ACH_T_AT && has_p && !is_ac) act_r[pi] <= pv_r;
          end
          if (apply) pvb_r <= 16'h0;
          else if (at_do && typ_r == `ACH_T_ATQ && has_p && !is_ac) pvb_r[pi] <= 1'b1;
        end
        default: ps_r <= P_SYNC;
      endcase
    end
  end

  // ========================================================================
  // Payload register toward the network
  always @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      nv_r <= 1'b0; nd_r <= 8'h0; nl_r <= 1'b0; done_r <= 1'b0; dok_r <= 1'b0;
    end else begin
      if (nv_r && NET_TX_READY) nv_r <= 1'b0;
      if (take && fwd_sel) begin
        nv_r <= 1'b1;
        nd_r <= SER_RX_DATA;
        nl_r <= idx_r + 16'h1 == len_r || pay_n + 16'h1 == `ACH_MAX_PAY;
      end
      done_r <= sum_take && is_tx && rdone_r && (err_r == `ACH_ST_OK || err_r == `ACH_ST_LONG);
      dok_r <= sum_ok && err_r == `ACH_ST_OK;
    end
  end

  // ========================================================================
  // Socket table and idle timeout
  wire tick = tk_r == TICK_CYC - 1;
  always @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      sk_v_r <= {NSOCK{1'b0}}; open_r <= {NSOCK{1'b0}}; close_r <= {NSOCK{1'b0}};
      tk_r <= 32'h0;
      for (s = 0; s < NSOCK; s = s + 1) begin
        sk_a_r[s] <= 32'h0; sk_dp_r[s] <= 16'h0; sk_sp_r[s] <= 16'h0;
        sk_pr_r[s] <= 8'h0; idle_r[s] <= 8'h0;
      end
    end else begin
      open_r <= {NSOCK{1'b0}};
      close_r <= {NSOCK{1'b0}};
      tk_r <= tick ? 32'h0 : tk_r + 32'h1;
      for (s = 0; s < NSOCK; s = s + 1) begin
        if (alloc && f_i == s[SW-1:0]) begin
          sk_v_r[s] <= 1'b1; open_r[s] <= 1'b1; idle_r[s] <= 8'h0;
          sk_a_r[s] <= addr_r; sk_dp_r[s] <= dport_r;
          sk_sp_r[s] <= sport_r; sk_pr_r[s] <= proto_r;
        end else if (sk_v_r[s]) begin
          // A zero timeout keeps sockets open until closed by request.
          if ((tcp_close && sock_r == s[SW-1:0]) ||
              (CONN_TIMEOUT != 8'h00 && idle_r[s] >= CONN_TIMEOUT)) begin
            sk_v_r[s] <= 1'b0;
            close_r[s] <= 1'b1;
          end else if ((take && fwd_sel && sock_r == s[SW-1:0]) ||
                       (rx_mv && kind_r == K_RX && rxs_r == s[SW-1:0])) idle_r[s] <= 8'h0;
          else if (tick && idle_r[s] != 8'hff) idle_r[s] <= idle_r[s] + 8'h1;
        end
      end
    end
  end

  // ========================================================================
  // Response and receive packet header bytes
  reg [3:0]  hn;
  reg [15:0] hl;
  always @* begin
    hb = 8'h00;
    case (kind_r)
      K_AT: begin hn = at_hv_r ? 4'd9 : 4'd8; hl = at_hv_r ? 16'd6 : 16'd5; end
      K_ST: begin hn = 4'd6; hl = 16'd3; end
      default: begin hn = 4'd13; hl = 16'd10 + rxl_r; end
    endcase
    case (oi_r)
      4'd0: hb = `ACH_DELIM;
      4'd1: hb = hl[15:8];
      4'd2: hb = hl[7:0];
      4'd3: hb = kind_r == K_AT ? `ACH_T_ATR : kind_r == K_ST ? `ACH_T_ST : `ACH_T_RX;
      default: ;
    endcase
    if (oi_r > 4'd3) begin
      case (kind_r)
        K_AT: case (oi_r)
          4'd4: hb = at_id_r;
          4'd5: hb = at_c1_r;
          4'd6: hb = at_c2_r;
          4'd7: hb = `ACH_ST_OK;
          default: hb = at_val_r;
        endcase
        K_ST: hb = oi_r == 4'd4 ? st_id_r : st_code_r;
        default: case (oi_r)
          4'd4: hb = sk_a_r[rxs_r][31:24];
          4'd5: hb = sk_a_r[rxs_r][23:16];
          4'd6: hb = sk_a_r[rxs_r][15:8];
          4'd7: hb = sk_a_r[rxs_r][7:0];
          4'd8: hb = sk_dp_r[rxs_r][15:8];
          4'd9: hb = sk_dp_r[rxs_r][7:0];
          4'd10: hb = sk_sp_r[rxs_r][15:8];
          4'd11: hb = sk_sp_r[rxs_r][7:0];
          default: hb = sk_pr_r[rxs_r];
        endcase
      endcase
    end
  end

  // ========================================================================
  // Emitter and two-entry output buffer
  always @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      os_r <= O_IDLE; kind_r <= K_AT; oi_r <= 4'h0; osum_r <= 8'h0;
      rxs_r <= {SW{1'b0}}; rxl_r <= 16'h0; fw_r <= 1'b0; fr_r <= 1'b0; fc_r <= 2'h0;
      fm_r[0] <= 8'h0; fm_r[1] <= 8'h0;
    end else begin
      if (f_in) begin
        fm_r[fw_r] <= f_d;
        fw_r <= ~fw_r;
      end
      if (f_out) fr_r <= ~fr_r;
      fc_r <= fc_r + {1'b0, f_in} - {1'b0, f_out};
      case (os_r)
        O_IDLE: begin
          oi_r <= 4'h0;
          osum_r <= 8'h0;
          if (at_pend_r) begin kind_r <= K_AT; os_r <= O_HDR; end
          else if (st_pend_r) begin kind_r <= K_ST; os_r <= O_HDR; end
          else if (NET_RX_VALID) begin
            kind_r <= K_RX; rxs_r <= NET_RX_SOCK; rxl_r <= NET_RX_LEN; os_r <= O_HDR;
          end
        end
        O_HDR: if (f_in) begin
          oi_r <= oi_r + 4'h1;
          if (oi_r >= 4'd3) osum_r <= osum_r + hb;
          if (oi_r == hn - 4'd1)
            os_r <= (kind_r == K_RX && rxl_r != 16'h0) ? O_PAY : O_SUM;
        end
        O_PAY: if (f_in) begin
          osum_r <= osum_r + NET_RX_DATA;
          if (NET_RX_LAST) os_r <= O_SUM;
        end
        default: if (f_in) os_r <= O_IDLE;
      endcase
    end
  end

  assign SER_RX_READY = rx_rdy;
  assign SER_TX_VALID = fc_r != 2'h0;
  assign SER_TX_DATA  = fm_r[fr_r];
  assign NET_TX_VALID = nv_r;
  assign NET_TX_DATA  = nd_r;
  assign NET_TX_LAST  = nl_r;
  assign NET_TX_SOCK  = sock_r;
  assign NET_TX_DONE  = done_r;
  assign NET_TX_OK    = dok_r;
  assign NET_OPEN     = open_r;
  assign NET_CLOSE    = close_r;
  assign NET_ADDR     = addr_r;
  assign NET_DPORT    = dport_r;
  assign NET_SPORT    = sport_r;
  assign NET_PROTO    = proto_r;
  assign NET_RX_READY = rx_mv;
  assign CONN_TIMEOUT = act_r[pidx(`ACH_TM1, `ACH_TM2)];
  assign SUM_ERR      = serr_r;

endmodule // ach_frame_handler

`default_nettype wire

/* testbench/ach_frame_handler_monitor.sv */
/*
  Checker for the frame handler: handshake holding, pulse widths and
  causes of network strobes. Assumes binding to ach_frame_handler.
*/
`timescale 1ns/100ps
`default_nettype none
module ach_frame_handler_monitor #(
  parameter NSOCK = 7,
  parameter SW    = 3
) (
  // Clock and reset
  input wire logic             CLK_SYS,
  input wire logic             RST,
  // Serial side
  input wire logic             SER_RX_VALID,
  input wire logic             SER_RX_READY,
  input wire logic             SER_TX_VALID,
  input wire logic [7:0]       SER_TX_DATA,
  input wire logic             SER_TX_READY,
  // Network side
  input wire logic             NET_TX_VALID,
  input wire logic [7:0]       NET_TX_DATA,
  input wire logic             NET_TX_READY,
  input wire logic             NET_TX_DONE,
  input wire logic [NSOCK-1:0] NET_OPEN,
  input wire logic [NSOCK-1:0] NET_CLOSE,
  input wire logic             SUM_ERR
);
  // ==========================================================
  // Properties
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  sequence s_ser_stall;
    SER_TX_VALID && !SER_TX_READY;
  endsequence
  sequence s_net_stall;
    NET_TX_VALID && !NET_TX_READY;
  endsequence
  a_ser_out_hold: assert property (s_ser_stall |=> SER_TX_VALID && $stable(SER_TX_DATA))
    else $error("serial out byte changed before it was taken");
  a_net_out_hold: assert property (s_net_stall |=> NET_TX_VALID && $stable(NET_TX_DATA))
    else $error("network byte changed before it was taken");
  a_done_one_cycle: assert property (NET_TX_DONE |=> !NET_TX_DONE)
    else $error("transmit done longer than one cycle");
  a_sum_err_pulse: assert property (SUM_ERR |=> !SUM_ERR)
    else $error("checksum error flag longer than one cycle");
  a_open_one_socket: assert property ($onehot0(NET_OPEN))
    else $error("more than one socket opened at once");
  a_close_bit_pulse: assert property ((NET_CLOSE != '0) |=> ((NET_CLOSE & $past(NET_CLOSE)) == '0))
    else $error("socket close strobe longer than one cycle");
  a_done_after_take: assert property (NET_TX_DONE |-> $past(SER_RX_VALID && SER_RX_READY))
    else $error("transmit done without a checksum byte just taken");
  a_net_valid_cause: assert property ($rose(NET_TX_VALID) |-> $past(SER_RX_VALID && SER_RX_READY))
    else $error("network byte appeared without a serial byte taken");
endmodule // ach_frame_handler_monitor
bind ach_frame_handler ach_frame_handler_monitor #(.NSOCK(NSOCK), .SW(SW)) u_mon (
  .CLK_SYS(CLK_SYS), .RST(RST), .SER_RX_VALID(SER_RX_VALID), .SER_RX_READY(SER_RX_READY),
  .SER_TX_VALID(SER_TX_VALID), .SER_TX_DATA(SER_TX_DATA), .SER_TX_READY(SER_TX_READY),
  .NET_TX_VALID(NET_TX_VALID), .NET_TX_DATA(NET_TX_DATA), .NET_TX_READY(NET_TX_READY),
  .NET_TX_DONE(NET_TX_DONE), .NET_OPEN(NET_OPEN), .NET_CLOSE(NET_CLOSE), .SUM_ERR(SUM_ERR));
`default_nettype wire

/* testbench/ach_net_model.sv */
/*
  Network stack model: takes payload bytes with random stalls and offers
  received packets on request. Assumes the handler's network ports.
*/
`timescale 1ns/100ps
`default_nettype none
module ach_net_model #(
  parameter SW = 3
) (
  input wire logic  clk,
  input wire logic  rst,
  output logic          tx_ready,
  output logic          rx_valid,
  output logic [7:0]    rx_data,
  output logic          rx_last,
  output logic [SW-1:0] rx_sock,
  output logic [15:0]   rx_len,
  input wire logic  rx_ready
);
  initial begin
    tx_ready = 1'b0;
    rx_valid = 1'b0;
    rx_data  = 8'h5a;
    rx_last  = 1'b0;
    rx_sock  = '0;
    rx_len   = 16'h0000;
  end
  // A real stack is not always free, so stall about one cycle in three.
  always @(posedge clk) begin
    tx_ready <= !rst && ($urandom % 3 != 0);
  end
  // One-byte packet on an open socket.
  task automatic send(input logic [SW-1:0] s, input logic [7:0] b);
    int n;
    logic ok;
    @(posedge clk);
    rx_sock  <= s;
    rx_len   <= 16'h0001;
    rx_data  <= b;
    rx_last  <= 1'b1;
    rx_valid <= 1'b1;
    n = 0;
    do begin
      @(negedge clk);
      ok = rx_ready;
      @(posedge clk);
      n++;
    end while (!ok && n < 500);
    // A released bus shows no stale value.
    rx_valid <= 1'b0;
    rx_last  <= 1'b0;
    rx_data  <= ~b;
  endtask
endmodule // ach_net_model
`default_nettype wire

/* testbench/ach_frame_handler_tb.sv */
/*
  Self-checking bench for the frame handler. Assumes TICK_CYC shortened
  to 4 cycles so idle timeouts finish quickly.
*/
`timescale 1ns/100ps
`default_nettype none
module ach_frame_handler_tb;
  logic CLK_SYS, RST, SER_RX_VALID, SER_RX_READY, SER_TX_VALID, SER_TX_READY;
  logic [7:0] SER_RX_DATA, SER_TX_DATA, NET_TX_DATA, NET_RX_DATA, CONN_TIMEOUT;
  logic NET_TX_VALID, NET_TX_LAST, NET_TX_READY, NET_TX_DONE, NET_TX_OK;
  logic NET_RX_VALID, NET_RX_LAST, NET_RX_READY, SUM_ERR;
  logic [2:0] NET_TX_SOCK, NET_RX_SOCK, sock_a;
  logic [6:0] NET_OPEN, NET_CLOSE;
  logic [31:0] NET_ADDR, exp_a;
  logic [8:0] e_n;
  logic [15:0] NET_DPORT, NET_SPORT, NET_RX_LEN;
  logic [7:0] NET_PROTO, ser_q[$], net_q[$], d[$];
  int fail_count = 0, n_compared = 0, n_open = 0, n_close = 0, n_serr = 0, n_done = 0;
  // ==========================================================
  // Design and far side
  ach_frame_handler #(.NSOCK(7), .SW(3), .TICK_CYC(4)) DUT (
    .CLK_SYS(CLK_SYS), .RST(RST), .SER_RX_VALID(SER_RX_VALID), .SER_RX_DATA(SER_RX_DATA),
    .SER_RX_READY(SER_RX_READY), .SER_TX_VALID(SER_TX_VALID), .SER_TX_DATA(SER_TX_DATA),
    .SER_TX_READY(SER_TX_READY), .NET_TX_VALID(NET_TX_VALID), .NET_TX_DATA(NET_TX_DATA),
    .NET_TX_LAST(NET_TX_LAST), .NET_TX_SOCK(NET_TX_SOCK), .NET_TX_READY(NET_TX_READY),
    .NET_TX_DONE(NET_TX_DONE), .NET_TX_OK(NET_TX_OK), .NET_OPEN(NET_OPEN),
    .NET_CLOSE(NET_CLOSE), .NET_ADDR(NET_ADDR), .NET_DPORT(NET_DPORT), .NET_SPORT(NET_SPORT),
    .NET_PROTO(NET_PROTO), .NET_RX_VALID(NET_RX_VALID), .NET_RX_DATA(NET_RX_DATA),
    .NET_RX_LAST(NET_RX_LAST), .NET_RX_SOCK(NET_RX_SOCK), .NET_RX_LEN(NET_RX_LEN),
    .NET_RX_READY(NET_RX_READY), .CONN_TIMEOUT(CONN_TIMEOUT), .SUM_ERR(SUM_ERR));
  ach_net_model #(.SW(3)) u_net (.clk(CLK_SYS), .rst(RST), .tx_ready(NET_TX_READY),
    .rx_valid(NET_RX_VALID), .rx_data(NET_RX_DATA), .rx_last(NET_RX_LAST),
    .rx_sock(NET_RX_SOCK), .rx_len(NET_RX_LEN), .rx_ready(NET_RX_READY));
  initial begin
    CLK_SYS = 1'b0;
    forever #10 CLK_SYS = ~CLK_SYS;
  end
  // ==========================================================
  // Checking
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge CLK_SYS) begin
    SER_TX_READY <= !RST && ($urandom % 4 != 0);
    if (!RST) begin
      n_open  += $countones(NET_OPEN);
      n_close += $countones(NET_CLOSE);
      if (SER_TX_VALID && SER_TX_READY)
        check(SER_TX_DATA, ser_q.size() ? ser_q.pop_front() : 9'h100);
      n_serr  += SUM_ERR;
      n_done  += NET_TX_DONE;
      if (NET_TX_DONE) check(NET_TX_OK, 1'b1);
      if (NET_OPEN != 7'h00) check(NET_ADDR, exp_a);
      if (NET_OPEN != 7'h00) check({NET_DPORT, NET_SPORT}, 32'h1f900000);
      if (NET_TX_VALID && NET_TX_READY) begin
        sock_a <= (n_open == 1) ? NET_TX_SOCK : sock_a;
        e_n = net_q.size() ? {net_q.size() == 1, net_q[0]} : 9'h100;
        check({NET_TX_LAST, NET_TX_DATA}, e_n);
        if (net_q.size()) void'(net_q.pop_front());
      end
    end
  end
  // ==========================================================
  // Host side frames
  task automatic wrap(input logic [7:0] f[$], output logic [7:0] o[$]);
    logic [7:0] s = 8'h00;
    foreach (f[i]) s += f[i];
    o = {8'h7e, 8'(f.size() >> 8), 8'(f.size())};
    o = {o, f, 8'hff - s};
  endtask
  task automatic send(input logic [7:0] f[$], input logic bad);
    logic [7:0] o[$];
    logic ok;
    int n;
    wrap(f, o);
    o[o.size()-1] ^= {7'h0, bad};
    @(posedge CLK_SYS);
    foreach (o[i]) begin
      SER_RX_VALID <= 1'b1;
      SER_RX_DATA  <= o[i];
      n = 0;
      do begin
        @(negedge CLK_SYS);
        ok = SER_RX_READY;
        @(posedge CLK_SYS);
        n++;
      end while (!ok && n < 3000);
      if (!ok) begin
        fail_count++;
        tally_and_finish;
      end
    end
    SER_RX_VALID <= 1'b0;
  endtask
  task automatic expect_frame(input logic [7:0] f[$]);
    logic [7:0] o[$];
    wrap(f, o);
    ser_q = {ser_q, o};
  endtask
  task automatic drain;
    int n;
    for (n = 0; n < 8000 && (ser_q.size() || net_q.size()); n++) @(negedge CLK_SYS);
    if (n >= 8000) begin
      fail_count++;
      tally_and_finish;
    end
    repeat (4) @(negedge CLK_SYS);
  endtask
  // Transmit request; the host keeps reserved option bits clear.
  task automatic tx(input logic [7:0] id, input logic [31:0] a, input logic [15:0] sp,
                    input logic [7:0] pr, op, st, input int n);
    logic [7:0] b;
    d = {8'h20, id, a[31:24], a[23:16], a[15:8], a[7:0], 8'h1f, 8'h90, sp[15:8], sp[7:0],
         pr, op};
    exp_a = a;
    repeat (n) begin
      b = 8'($urandom);
      d.push_back(b);
      if (st == 8'h00) net_q.push_back(b);
    end
    if (id != 8'h00) expect_frame({8'h89, id, st});
    send(d, 1'b0);
    drain();
  endtask
  // Command frame; the name travels as two ASCII bytes.
  task automatic at(input logic [7:0] t, id, c1, c2, input logic np, input logic [7:0] p,
                    input logic nv, input logic [7:0] v, input logic bad);
    d = {t, id, c1, c2};
    if (np) d.push_back(p);
    if (id != 8'h00 && !bad) begin
      if (nv) expect_frame({8'h88, id, c1, c2, 8'h00, v});
      else expect_frame({8'h88, id, c1, c2, 8'h00});
    end
    send(d, bad);
    drain();
  endtask
  // ==========================================================
  // Scenarios
  initial begin
    RST = 1'b1;
    SER_RX_VALID = 1'b0;
    SER_RX_DATA = 8'h00;
    SER_TX_READY = 1'b0;
    void'($urandom(47));
    repeat (16) @(posedge CLK_SYS);
    RST <= 1'b0;
    tx(8'h05, 32'h0a000001, 16'h0000, 8'h00, 8'h00, 8'h00, 2);
    check(n_open, 1);
    tx(8'h06, 32'h0a000001, 16'h0000, 8'h00, 8'h02, 8'h00, 1500);
    check(n_open, 1);
    tx(8'h07, 32'h0a000001, 16'h1234, 8'h00, 8'h00, 8'h83, 1);
    tx(8'h00, 32'h0a000002, 16'h0000, 8'h01, 8'h02, 8'h00, 1);
    check(n_close, 1);
    tx(8'h08, 32'h0a000003, 16'h0000, 8'h01, 8'h00, 8'h00, 1);
    check(n_open, 3);
    check(n_close, 1);
    expect_frame({8'hb0, 8'h0a, 8'h00, 8'h00, 8'h01, 8'h1f, 8'h90, 8'h00, 8'h00, 8'h00, 8'hc3});
    u_net.send(sock_a, 8'hc3);
    drain();
    at(8'h08, 8'h01, 8'h54, 8'h4d, 0, 8'h00, 1, 8'h00, 0);
    at(8'h09, 8'h02, 8'h54, 8'h4d, 1, 8'h03, 0, 8'h00, 0);
    check(CONN_TIMEOUT, 8'h00);
    at(8'h09, 8'h03, 8'h54, 8'h4d, 0, 8'h00, 1, 8'h00, 0);
    at(8'h08, 8'h04, 8'h54, 8'h4d, 1, 8'h09, 0, 8'h00, 1);
    check(n_serr, 1);
    at(8'h09, 8'h00, 8'h41, 8'h43, 0, 8'h00, 0, 8'h00, 0);
    check(CONN_TIMEOUT, 8'h03);
    at(8'h09, 8'h00, 8'h54, 8'h4d, 1, 8'h04, 0, 8'h00, 0);
    at(8'h08, 8'h05, 8'h54, 8'h4d, 0, 8'h00, 1, 8'h04, 0);
    check(CONN_TIMEOUT, 8'h04);
    for (int n = 0; n < 400 && n_close < 3; n++) @(negedge CLK_SYS);
    check(n_close, 3);
    check(n_done, 4);
    tally_and_finish;
  end
endmodule // ach_frame_handler_tb
`default_nettype wire
